// ---- design/rts_defs.svh ----
/*
 Timing, code and field constants for the regulator thermal supervisor.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH
`define RTS_CLK_MHZ        200
`define RTS_FILT_TYP_US    20
`define RTS_FILT_MAX_US    30
`define RTS_ST_CYCLES      4
`define RTS_ADDR_STATUS    4'h0
`define RTS_ADDR_MASK      4'h1
`define RTS_ADDR_CFG       4'h2
`define RTS_ADDR_SELFTEST  4'h3
`define RTS_ADDR_REGEN     4'h4
`define RTS_THR_MAX_CODE   3'h5
`define RTS_THR_BASE_C     8'h4B
`define RTS_THR_STEP_C     8'h0F
`define RTS_IRQ_DIE        0
`define RTS_IRQ_OT         1
`define RTS_IRQ_SELFTEST   2
`define RTS_IRQ_FAILSAFE   3
`endif

// ---- design/rts_pkg.sv ----
/*
 Types for the regulator thermal supervisor.
 Assumes rts_defs.svh is on the include path.
*/
`include "rts_defs.svh"
package rts_pkg;
  typedef enum logic [1:0] {
    RTS_ST_IDLE = 2'b00,
    RTS_ST_HIGH = 2'b01,
    RTS_ST_LOW  = 2'b11,
    RTS_ST_RUN  = 2'b10
  } rts_phase_t;
  typedef struct packed {
    logic [2:0] die_thr_code;
    logic [7:0] die_temp;
  } rts_die_t;
endpackage

// ---- design/rts_supervisor.sv ----
/*
 Regulator thermal supervisor: per regulator overheat filter, shutdown,
 restart, sensor self-test at startup, centre-die interrupt, register port.
 Assumes inputs synchronous to clock_i; sensor test drive loops back through
 the analog sensors; startup_i is a one-cycle pulse.
*/
`include "rts_defs.svh"
module rts_supervisor #(
  parameter int N_REG    = 8,
  parameter int FILT_CYC = `RTS_FILT_TYP_US * `RTS_CLK_MHZ
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               startup_i,
  input  wire logic [N_REG-1:0]   overheat_cutoff_i,
  input  wire rts_pkg::rts_die_t  die_i,
  input  wire logic [3:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic [31:0]             rdata_o,
  output logic [N_REG-1:0]        reg_on_o,
  output logic [N_REG-1:0]        sensor_test_o,
  output logic                    deep_failsafe_o,
  output logic                    irq_o
);
  localparam int FILT_MAX = `RTS_FILT_MAX_US * `RTS_CLK_MHZ;
  localparam int CW       = $clog2(FILT_MAX + 1);
  localparam logic [CW-1:0] FILT_LIM = CW'(FILT_CYC - 1);

  typedef struct packed {
    logic [N_REG-1:0][CW-1:0] filt;
    logic [N_REG-1:0]         hot;
    logic [N_REG-1:0]         cut;
    logic [N_REG-1:0]         regen;
    logic [N_REG-1:0]         fsmode;
    logic [N_REG-1:0]         stim;
    logic                     fs;
    rts_pkg::rts_phase_t      ph;
    logic [2:0]               stcnt;
    logic                     fault;
    logic                     die_hot;
    logic [3:0]               stat;
    logic [3:0]               mask;
    logic [31:0]              rdata;
    logic                     irq;
    logic [N_REG-1:0]         reg_on;
  } st_t;

  st_t s_r, s_nxt;
  logic [7:0] thr_c;
  logic [2:0] code_eff;

  always_comb begin
    code_eff = (die_i.die_thr_code > `RTS_THR_MAX_CODE) ? `RTS_THR_MAX_CODE
                                                        : die_i.die_thr_code;
    thr_c = `RTS_THR_BASE_C + 8'(`RTS_THR_STEP_C * code_eff);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0;
    // Overheat filter and response per regulator
    for (int i = 0; i < N_REG; i++) begin
      if (s_r.ph != rts_pkg::RTS_ST_RUN || !overheat_cutoff_i[i]) begin
        s_nxt.filt[i] = '0;
        s_nxt.hot[i]  = 1'b0;
      end else if (s_r.filt[i] == FILT_LIM) begin
        s_nxt.hot[i]  = 1'b1;
      end else begin
        s_nxt.filt[i] = s_r.filt[i] + CW'(1);
      end
      if (s_r.hot[i] && !s_r.cut[i]) begin
        s_nxt.cut[i] = 1'b1;
        s_nxt.stat[`RTS_IRQ_OT] = 1'b1;
        if (s_r.fsmode[i]) begin
          s_nxt.fs = 1'b1;
          s_nxt.stat[`RTS_IRQ_FAILSAFE] = 1'b1;
        end
      end else if (s_r.cut[i] && !overheat_cutoff_i[i] && !s_r.fsmode[i] && !s_r.fs) begin
        s_nxt.cut[i] = 1'b0;
      end
    end
    // Startup self-test: drive sensors high, then low
    case (s_r.ph)
      rts_pkg::RTS_ST_IDLE: begin
        s_nxt.stim  = '1;
        s_nxt.stcnt = '0;
        s_nxt.ph    = rts_pkg::RTS_ST_HIGH;
      end
      rts_pkg::RTS_ST_HIGH: begin
        s_nxt.stcnt = s_r.stcnt + 3'h1;
        if (s_r.stcnt == 3'(`RTS_ST_CYCLES - 1)) begin
          if (overheat_cutoff_i != '1) begin
            s_nxt.fault = 1'b1;
          end
          s_nxt.stim  = '0;
          s_nxt.stcnt = '0;
          s_nxt.ph    = rts_pkg::RTS_ST_LOW;
        end
      end
      rts_pkg::RTS_ST_LOW: begin
        s_nxt.stcnt = s_r.stcnt + 3'h1;
        if (s_r.stcnt == 3'(`RTS_ST_CYCLES - 1)) begin
          if (overheat_cutoff_i != '0) begin
            s_nxt.fault = 1'b1;
          end
          s_nxt.ph = rts_pkg::RTS_ST_RUN;
        end
      end
      default: begin
        s_nxt.ph = rts_pkg::RTS_ST_RUN;
      end
    endcase
    if (s_nxt.fault && !s_r.fault) begin
      s_nxt.stat[`RTS_IRQ_SELFTEST] = 1'b1;
    end
    // Centre-die threshold crossing event
    s_nxt.die_hot = die_i.die_temp > thr_c;
    // Register port
    if (wr_i) begin
      if (addr_i == `RTS_ADDR_MASK) begin
        s_nxt.mask = wdata_i[3:0];
      end else if (addr_i == `RTS_ADDR_CFG) begin
        s_nxt.fsmode = wdata_i[N_REG-1:0];
      end else if (addr_i == `RTS_ADDR_REGEN) begin
        s_nxt.regen = wdata_i[N_REG-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == `RTS_ADDR_STATUS) begin
        s_nxt.rdata = {28'h0, s_r.stat};
        s_nxt.stat  = 4'h0;
      end else if (addr_i == `RTS_ADDR_MASK) begin
        s_nxt.rdata = {28'h0, s_r.mask};
      end else if (addr_i == `RTS_ADDR_CFG) begin
        s_nxt.rdata = 32'(s_r.fsmode);
      end else if (addr_i == `RTS_ADDR_SELFTEST) begin
        s_nxt.rdata = {s_r.fs, s_r.die_hot, 29'h0, s_r.fault};
      end else if (addr_i == `RTS_ADDR_REGEN) begin
        s_nxt.rdata = 32'(s_r.regen);
      end
    end
    // Event sets win over the read clear
    if (s_nxt.die_hot && !s_r.die_hot) begin
      s_nxt.stat[`RTS_IRQ_DIE] = 1'b1;
    end
    for (int i = 0; i < N_REG; i++) begin
      if (s_r.hot[i] && !s_r.cut[i]) begin
        s_nxt.stat[`RTS_IRQ_OT] = 1'b1;
        if (s_r.fsmode[i]) begin
          s_nxt.stat[`RTS_IRQ_FAILSAFE] = 1'b1;
        end
      end
    end
    if (s_nxt.fault && !s_r.fault) begin
      s_nxt.stat[`RTS_IRQ_SELFTEST] = 1'b1;
    end
    if (startup_i) begin
      s_nxt.ph    = rts_pkg::RTS_ST_IDLE;
      s_nxt.fault = 1'b0;
      s_nxt.fs    = 1'b0;
      s_nxt.cut   = '0;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // Enables leave straight from a flop, in the same cycle as the state that gates them
    s_nxt.reg_on = s_nxt.regen & ~s_nxt.cut & {N_REG{~s_nxt.fs}};
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r    <= '0;
      s_r.regen <= '1;
      s_r.reg_on <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o         = s_r.rdata;
  assign sensor_test_o   = s_r.stim;
  assign deep_failsafe_o = s_r.fs;
  assign irq_o           = s_r.irq;
  assign reg_on_o        = s_r.reg_on;

  // Assertions
  logic [N_REG-1:0] oh_q1;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      oh_q1 <= '0;
    end else begin
      oh_q1 <= overheat_cutoff_i;
    end
  end

  filt_no_early_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(s_r.hot[0]) |-> $past(overheat_cutoff_i[0], 1) && $past(s_r.filt[0], 1) == FILT_LIM)
    else $error("overheat accepted before filter expired");
  filt_bound_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.filt[0] <= FILT_LIM)
    else $error("filter count past its limit");
  cut_follows_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.hot[0] && !s_r.cut[0] |=> s_r.cut[0] && !reg_on_o[0])
    else $error("regulator not cut on overheat");
  cut_isolated_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    $rose(s_r.cut[1]) |-> $past(s_r.hot[1]))
    else $error("regulator cut without own overheat");
  failsafe_mode_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.hot[0] && !s_r.cut[0] && s_r.fsmode[0] |=> deep_failsafe_o)
    else $error("fail-safe not entered");
  restart_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.cut[0] && !overheat_cutoff_i[0] && !s_r.fsmode[0] && !s_r.fs |=> !s_r.cut[0])
    else $error("no automatic restart");
  selftest_high_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_HIGH && s_r.stcnt == 3'(`RTS_ST_CYCLES - 1)
      && overheat_cutoff_i != '1 |=> s_r.fault)
    else $error("stuck-low sensor not flagged");
  die_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(s_r.die_hot) |-> s_r.stat[`RTS_IRQ_DIE])
    else $error("die threshold event lost");
  thr_clamp_a: assert property (@(posedge clock_i) disable iff (rst_i)
    die_i.die_thr_code[2:1] == 2'b11 |-> thr_c == 8'h96)
    else $error("reserved code not clamped");
  irq_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
    irq_o == |(s_r.stat & s_r.mask))
    else $error("interrupt output mismatch");

  // Self-test sequence
  selftest_low_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_LOW && s_r.stcnt == 3'(`RTS_ST_CYCLES - 1)
      && overheat_cutoff_i != '0 |=> s_r.fault)
    else $error("stuck-high sensor not flagged");
  drive_high_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.ph == rts_pkg::RTS_ST_HIGH |-> sensor_test_o == '1)
    else $error("sensors not driven high in test");
  drive_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.ph == rts_pkg::RTS_ST_RUN |-> sensor_test_o == '0)
    else $error("sensor drive left on in run");
  phase_order_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_HIGH |=> s_r.ph inside {rts_pkg::RTS_ST_HIGH, rts_pkg::RTS_ST_LOW})
    else $error("self-test phase skipped");
  idle_to_high_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_IDLE |=> s_r.ph == rts_pkg::RTS_ST_HIGH)
    else $error("self-test did not start");
  high_to_low_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_HIGH && s_r.stcnt == 3'(`RTS_ST_CYCLES - 1)
      |=> s_r.ph == rts_pkg::RTS_ST_LOW && sensor_test_o == '0)
    else $error("self-test low phase not entered");
  selftest_run_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.ph == rts_pkg::RTS_ST_LOW && s_r.stcnt == 3'(`RTS_ST_CYCLES - 1) |=> s_r.ph == rts_pkg::RTS_ST_RUN)
    else $error("self-test did not finish");
  fault_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    s_r.fault |=> s_r.fault)
    else $error("fault flag lost");

  // Register port
  mask_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && addr_i == `RTS_ADDR_MASK |=> s_r.mask == $past(wdata_i[3:0]))
    else $error("mask write lost");
  cfg_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && addr_i == `RTS_ADDR_CFG |=> s_r.fsmode == $past(wdata_i[N_REG-1:0]))
    else $error("response config write lost");
  regen_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && addr_i == `RTS_ADDR_REGEN |=> s_r.regen == $past(wdata_i[N_REG-1:0]))
    else $error("enable write lost");
  status_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_STATUS |=> rdata_o == {28'h0, $past(s_r.stat)})
    else $error("status read data wrong");
  mask_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_MASK |=> rdata_o == {28'h0, $past(s_r.mask)})
    else $error("mask read data wrong");
  cfg_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_CFG |=> rdata_o == 32'($past(s_r.fsmode)))
    else $error("config read data wrong");
  regen_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_REGEN |=> rdata_o == 32'($past(s_r.regen)))
    else $error("enable read data wrong");
  flags_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_SELFTEST
      |=> rdata_o == {$past(s_r.fs), $past(s_r.die_hot), 29'h0, $past(s_r.fault)})
    else $error("flag read data wrong");
  fault_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == `RTS_ADDR_SELFTEST |=> rdata_o[0] == $past(s_r.fault))
    else $error("fault flag not readable");
  rdata_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read answer");
  irq_masked_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s_r.mask == 4'h0 && !wr_i |=> !irq_o)
    else $error("masked interrupt raised");

  // Startup and sticky state
  ph_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    startup_i |=> s_r.ph == rts_pkg::RTS_ST_IDLE)
    else $error("startup did not restart self-test");
  startup_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    startup_i |=> !s_r.fault && !deep_failsafe_o && s_r.cut == '0)
    else $error("startup did not clear state");
  fs_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
    deep_failsafe_o |=> deep_failsafe_o)
    else $error("fail-safe state lost");

  // Per regulator: each filter answers only to its own sensor; deep fail-safe keeps each already cut regulator cut
  for (genvar g = 0; g < N_REG; g++) begin : g_reg_chk
    hot_own_a: assert property (@(posedge clock_i) disable iff (rst_i)
      s_r.hot[g] |-> oh_q1[g])
      else $error("overheat held without own sensor");
    cut_own_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
      $rose(s_r.cut[g]) |-> $past(s_r.hot[g]))
      else $error("regulator cut without own overheat");
    cut_next_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
      s_r.hot[g] && !s_r.cut[g] |=> s_r.cut[g])
      else $error("regulator not cut on overheat");
    fs_entry_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
      s_r.hot[g] && !s_r.cut[g] && s_r.fsmode[g] |=> s_r.fs)
      else $error("fail-safe not entered");
    fs_hold_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
      s_r.cut[g] && s_r.fs |=> s_r.cut[g])
      else $error("regulator restarted in fail-safe");
    restart_own_a: assert property (@(posedge clock_i) disable iff (rst_i || startup_i)
      s_r.cut[g] && !overheat_cutoff_i[g] && !s_r.fsmode[g] && !s_r.fs |=> !s_r.cut[g])
      else $error("no automatic restart");
    on_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
      reg_on_o[g] == (s_r.regen[g] && !s_r.cut[g] && !s_r.fs))
      else $error("regulator enable mismatch");
    stat_ot_a: assert property (@(posedge clock_i) disable iff (rst_i)
      s_r.hot[g] && !s_r.cut[g] |=> s_r.stat[`RTS_IRQ_OT])
      else $error("overheat event lost");
    fs_stat_a: assert property (@(posedge clock_i) disable iff (rst_i)
      s_r.hot[g] && !s_r.cut[g] && s_r.fsmode[g] |=> s_r.stat[`RTS_IRQ_FAILSAFE])
      else $error("fail-safe event lost");
  end

  cov_cut_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(s_r.cut[0]));
  cov_restart_c: cover property (@(posedge clock_i) disable iff (rst_i) $fell(s_r.cut[0]));
  cov_fs_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(deep_failsafe_o));
  cov_irq_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_o));
  cov_fault_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(s_r.fault));
endmodule // rts_supervisor

// ---- tb/rts_host.sv ----
/*
 Host-side model: drives the register port of the supervisor.
 Assumes one clock; rdata_i stands only in the cycle after a read.
*/
module rts_host (
  input  wire logic        clock_i,
  input  wire logic [31:0] rdata_i,
  output logic [3:0]       addr_o,
  output logic [31:0]      wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  // Answer is taken at the edge that closes its cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    @(posedge clock_i);
    q = rdata_i;
  endtask
endmodule // rts_host

// ---- tb/regulator_thermal_supervisor_test.sv ----
/*
 Self-checking bench for the regulator thermal supervisor.
 Assumes sensors loop the self-test drive back; FILT_CYC shortened to 8.
*/
module regulator_thermal_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clock_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              startup_i = 1'b0;
  logic [7:0]        heat = 8'h00;
  logic [7:0]        stuck = 8'h00;
  logic [7:0]        reg_on, stest;
  rts_pkg::rts_die_t die = '0;
  logic [3:0]        addr;
  logic [31:0]       wdata, rdata, d;
  logic              wr, rd, fsafe, irq;
  int                n_fail = 0;
  int                checks = 0;
  always #2.5 clock_i = ~clock_i;
  rts_supervisor #(.N_REG(8), .FILT_CYC(8)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .startup_i(startup_i),
    .overheat_cutoff_i(stest | heat | stuck), .die_i(die), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .reg_on_o(reg_on),
    .sensor_test_o(stest), .deep_failsafe_o(fsafe), .irq_o(irq));
  rts_host u_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic start;
    @(posedge clock_i) startup_i <= 1'b1;
    @(posedge clock_i) startup_i <= 1'b0;
    cyc(12);
  endtask
  function automatic logic [7:0] thr(input int c);
    return 8'(75 + 15 * ((c > 5) ? 5 : c));
  endfunction
  initial begin
    #(40000 * 5);
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h3997));
    cyc(16);
    rst_i <= 1'b0;
    cyc(12);
    chk("test drive", 32'h0, {24'h0, stest});
    u_host.rd(4'h4, d); chk("regen", 32'h000000FF, d);
    u_host.rd(4'h3, d); chk("fault flag", 32'h0, {31'h0, d[0]});
    u_host.rd(4'h9, d); chk("unmapped", 32'h0, d);
    u_host.wr(4'h2, 32'h00000002);
    u_host.wr(4'h1, 32'h0000000F);
    cyc(1);
    heat <= 8'h01;
    cyc(1 + $urandom % 6);
    heat <= 8'h00;
    cyc(4); chk("short burst", 32'hFF, {24'h0, reg_on});
    heat <= 8'h01;
    cyc(7); chk("filter hold", 32'h1, {31'h0, reg_on[0]});
    cyc(4); chk("own cut", 32'hFE, {24'h0, reg_on});
    u_host.rd(4'h0, d); chk("cut event", 32'h1, {31'h0, d[1]});
    cyc(1);
    heat <= 8'h00;
    cyc(3); chk("restart", 32'hFF, {24'h0, reg_on});
    heat <= 8'h02;
    cyc(12); chk("failsafe", 32'h1, {31'h0, fsafe});
    chk("all off", 32'h0, {24'h0, reg_on});
    heat <= 8'h00;
    cyc(3); chk("held off", 32'h0, {24'h0, reg_on});
    start();
    chk("after startup", 32'hFF, {24'h0, reg_on});
    stuck <= 8'h10;
    start();
    u_host.rd(4'h3, d); chk("stuck fault", 32'h1, {31'h0, d[0]});
    cyc(1);
    stuck <= 8'h00;
    start();
    u_host.rd(4'h3, d); chk("fault cleared", 32'h0, {31'h0, d[0]});
    u_host.rd(4'h0, d);
    for (int c = 0; c < 8; c++) begin
      cyc(1);
      die.die_thr_code <= 3'(c);
      die.die_temp <= 8'($urandom % thr(c));
      cyc(3);
      u_host.rd(4'h0, d);
      u_host.rd(4'h0, d); chk("below", 32'h0, {31'h0, d[0]});
      die.die_temp <= thr(c);
      cyc(3);
      u_host.rd(4'h0, d); chk("at thr", 32'h0, {31'h0, d[0]});
      die.die_temp <= thr(c) + 8'h01;
      cyc(3); chk("irq", 32'h1, {31'h0, irq});
      u_host.rd(4'h0, d); chk("above", 32'h1, {31'h0, d[0]});
      cyc(2); chk("irq clear", 32'h0, {31'h0, irq});
    end
    u_host.wr(4'h1, 32'h0);
    cyc(1);
    die.die_temp <= 8'h00;
    cyc(2);
    die.die_temp <= 8'hFF;
    cyc(3); chk("masked", 32'h0, {31'h0, irq});
    u_host.rd(4'h0, d); chk("masked event", 32'h1, {31'h0, d[0]});
    cyc(1); chk("idle rdata", 32'h0, rdata);
    report_and_stop();
  end
endmodule // regulator_thermal_supervisor_test
